// ==== verilog/uarr_receiver.sv ====
`timescale 1ns/1ps
module uarr_receiver #(
  parameter int DIV_W = 16,
  parameter int DATA_W = uarr_pkg::DATA_BITS
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_serial_input_pin,
  input wire logic i_receive_enable_bit,
  input wire logic i_double_speed_select,
  input wire logic i_parity_enable_bit,
  input wire logic i_parity_odd_select,
  input wire logic [DIV_W-1:0] i_baud_divisor_value,
  input wire logic i_serial_data_buffer_read,
  output logic [DATA_W-1:0] o_serial_data_buffer,
  output logic o_receive_complete_flag,
  output logic o_frame_error_flag,
  output logic o_parity_error_flag,
  output logic o_overrun_flag,
  output logic o_pin_override
);

  localparam int ENT_W = DATA_W + 3;  // data, frame err, parity err, overrun
  localparam int BUF_PTR_W = 2;

  typedef struct packed {
    uarr_pkg::uarr_phase_type phase;
    logic [3:0] sample;
    logic [2:0] votes;
    logic [3:0] bitcnt;
    logic [DATA_W-1:0] shift;
    logic par_acc;
    logic par_err;
    logic hold_full;
    logic [DATA_W-1:0] hold_data;
    logic hold_fe;
    logic hold_pe;
    logic ovr_pend;
    logic prev_line;
    logic [BUF_PTR_W-1:0] count;
    logic rd_ptr;
    logic [uarr_pkg::BUF_DEPTH*ENT_W-1:0] mem;
  } uarr_state_type;

  uarr_state_type st_reg;
  uarr_state_type st_next;
  logic tick;
  logic voted;
  logic [3:0] last_state;
  logic [3:0] vote_a;
  logic [3:0] vote_b;
  logic [3:0] vote_c;
  logic [ENT_W-1:0] head;

  // ----------------------------------------
  // Sample tick and voter
  // ----------------------------------------
  // sample rate
  uarr_tick_gen #(.DIV_W(DIV_W)) u_tick (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_run(i_receive_enable_bit),
    .i_divisor(i_baud_divisor_value),
    .o_tick(tick)
  );

  uarr_vote3 u_vote (
    .i_samples(st_reg.votes),
    .o_bit(voted)
  );

  always_comb begin
    last_state = i_double_speed_select ? uarr_pkg::DBL_LAST_STATE : uarr_pkg::NORM_LAST_STATE;
    vote_a = i_double_speed_select ? uarr_pkg::DBL_VOTE_A : uarr_pkg::NORM_VOTE_A;
    vote_b = i_double_speed_select ? uarr_pkg::DBL_VOTE_B : uarr_pkg::NORM_VOTE_B;
    vote_c = i_double_speed_select ? uarr_pkg::DBL_VOTE_C : uarr_pkg::NORM_VOTE_C;
  end

  // ----------------------------------------
  // Receiver state machine and buffer
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    // Reading pops the head entry
    if (i_serial_data_buffer_read && st_reg.count != '0) begin
      st_next.count = st_reg.count - 1'b1;
      st_next.rd_ptr = ~st_reg.rd_ptr;
    end
    // Hold register moves into buffer once room exists
    if (st_reg.hold_full && st_next.count != 2'(uarr_pkg::BUF_DEPTH)) begin
      if (st_next.rd_ptr ^ st_next.count[0]) begin
        st_next.mem[ENT_W +: ENT_W] = {st_reg.hold_data, st_reg.hold_fe, st_reg.hold_pe, st_reg.ovr_pend};
      end else begin
        st_next.mem[0 +: ENT_W] = {st_reg.hold_data, st_reg.hold_fe, st_reg.hold_pe, st_reg.ovr_pend};
      end
      st_next.count = st_next.count + 1'b1;
      st_next.hold_full = 1'b0;
      st_next.ovr_pend = 1'b0;
    end
    if (tick) begin
      st_next.prev_line = i_serial_input_pin;
      st_next.sample = st_reg.sample + 1'b1;
      if (st_reg.sample == vote_a) begin
        st_next.votes[0] = i_serial_input_pin;
      end
      if (st_reg.sample == vote_b) begin
        st_next.votes[1] = i_serial_input_pin;
      end
      if (st_reg.sample == vote_c) begin
        st_next.votes[2] = i_serial_input_pin;
      end
      unique case (st_reg.phase)
        uarr_pkg::RX_IDLE: begin
          if (st_reg.prev_line && !i_serial_input_pin) begin
            st_next.phase = uarr_pkg::RX_START;
            st_next.sample = 4'h2;
          end
        end
        uarr_pkg::RX_START: begin
          if (st_reg.sample == vote_c + 4'h1) begin
            if (voted) begin
              st_next.phase = uarr_pkg::RX_IDLE;
            end else begin
              st_next.phase = uarr_pkg::RX_DATA;
              st_next.bitcnt = '0;
              st_next.par_acc = 1'b0;
              if (st_next.count == 2'(uarr_pkg::BUF_DEPTH) && st_next.hold_full) begin
                st_next.ovr_pend = 1'b1;
              end
            end
          end
          // Count wraps to zero after the last state of a bit, keeps full bit length
          if (st_reg.sample == last_state) begin
            st_next.sample = '0;
          end
        end
        uarr_pkg::RX_DATA, uarr_pkg::RX_PARITY: begin
          // wrap after sixteenth or eighth state
          if (st_reg.sample == last_state) begin
            st_next.sample = '0;
          end
          if (st_reg.sample == vote_c + 4'h1) begin
            if (st_reg.phase == uarr_pkg::RX_DATA) begin
              st_next.shift = {voted, st_reg.shift[DATA_W-1:1]};
              st_next.par_acc = st_reg.par_acc ^ voted;
              st_next.bitcnt = st_reg.bitcnt + 1'b1;
              if (st_reg.bitcnt == 4'(DATA_W - 1)) begin
                st_next.phase = i_parity_enable_bit ? uarr_pkg::RX_PARITY : uarr_pkg::RX_STOP;
                st_next.par_err = 1'b0;
              end
            end else begin
              st_next.par_err = (st_reg.par_acc ^ voted) != i_parity_odd_select;
              st_next.phase = uarr_pkg::RX_STOP;
            end
          end
        end
        uarr_pkg::RX_STOP: begin
          if (st_reg.sample == vote_c) begin
            st_next.phase = uarr_pkg::RX_IDLE;
            st_next.prev_line = 1'b1;
            st_next.hold_full = 1'b1;
            st_next.hold_data = st_reg.shift;
            st_next.hold_fe = !((st_reg.votes[0] & st_reg.votes[1]) | (st_reg.votes[0] & i_serial_input_pin)
                               | (st_reg.votes[1] & i_serial_input_pin));
            st_next.hold_pe = i_parity_enable_bit & st_reg.par_err;
          end
        end
        default: st_next.phase = uarr_pkg::RX_IDLE;
      endcase
    end
    if (!i_receive_enable_bit) begin
      st_next.phase = uarr_pkg::RX_IDLE;
      st_next.count = '0;
      st_next.hold_full = 1'b0;
      st_next.ovr_pend = 1'b0;
      st_next.prev_line = 1'b1;
      st_next.sample = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= '{phase: uarr_pkg::RX_IDLE, prev_line: 1'b1, default: '0};
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs from head of buffer; pin override follows receive enable
  // ----------------------------------------
  assign head = st_reg.rd_ptr ? st_reg.mem[ENT_W +: ENT_W] : st_reg.mem[0 +: ENT_W];
  assign o_receive_complete_flag = st_reg.count != '0;
  assign o_serial_data_buffer = o_receive_complete_flag ? head[ENT_W-1:3] : '0;
  assign o_frame_error_flag = o_receive_complete_flag & head[2];
  assign o_parity_error_flag = o_receive_complete_flag & head[1];
  assign o_overrun_flag = o_receive_complete_flag & head[0];
  assign o_pin_override = i_receive_enable_bit;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_FLUSH_ON_DISABLE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && !i_receive_enable_bit) |=> !o_receive_complete_flag)
    else $error("buffer not flushed on disable");
  AST_IDLE_ON_DISABLE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && !i_receive_enable_bit) |=> st_reg.phase == uarr_pkg::RX_IDLE)
    else $error("frame not dropped on disable");
  AST_PIN_RELEASE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_receive_enable_bit |-> !o_pin_override)
    else $error("pin still overridden");
  AST_PE_ONLY_ENABLED: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && tick && st_reg.phase == uarr_pkg::RX_STOP && st_reg.sample == vote_c && !i_parity_enable_bit)
    |=> !st_reg.hold_pe)
    else $error("parity error stored while disabled");
  AST_COMPLETE_EMPTY: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_receive_enable_bit && st_reg.hold_full && st_reg.count != 2'(uarr_pkg::BUF_DEPTH))
    |=> o_receive_complete_flag)
    else $error("complete flag not raised on stored character");
  AST_COUNT_LIMIT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st_reg.count <= 2'(uarr_pkg::BUF_DEPTH))
    else $error("buffer count beyond depth");
  AST_NOISE_REJECT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && tick && i_receive_enable_bit && st_reg.phase == uarr_pkg::RX_START
     && st_reg.sample == vote_c + 4'h1 && voted) |=> st_reg.phase == uarr_pkg::RX_IDLE)
    else $error("noise start not rejected");
  AST_START_SYNC: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && tick && i_receive_enable_bit && st_reg.phase == uarr_pkg::RX_IDLE
     && st_reg.prev_line && !i_serial_input_pin) |=> st_reg.sample == 4'h2)
    else $error("start not resynchronised");

endmodule : uarr_receiver

// ==== shared/uarr_pkg.sv ====
package uarr_pkg;

  // ----------------------------------------
  // Oversampling and voting positions
  // ----------------------------------------
  localparam logic [3:0] NORM_LAST_STATE = 4'hF;  // 16 states per bit
  localparam logic [3:0] DBL_LAST_STATE = 4'h7;   // 8 states per bit
  localparam logic [3:0] NORM_VOTE_A = 4'h8;
  localparam logic [3:0] NORM_VOTE_B = 4'h9;
  localparam logic [3:0] NORM_VOTE_C = 4'hA;
  localparam logic [3:0] DBL_VOTE_A = 4'h4;
  localparam logic [3:0] DBL_VOTE_B = 4'h5;
  localparam logic [3:0] DBL_VOTE_C = 4'h6;

  // ----------------------------------------
  // Frame format and buffer
  // ----------------------------------------
  localparam int DATA_BITS = 8;
  localparam int BUF_DEPTH = 2;
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;

  // Receiver phases, one-hot
  typedef enum logic [4:0] {
    RX_IDLE   = 5'b00001,
    RX_START  = 5'b00010,
    RX_DATA   = 5'b00100,
    RX_PARITY = 5'b01000,
    RX_STOP   = 5'b10000
  } uarr_phase_type;

endpackage : uarr_pkg

// ==== verilog/uarr_tick_gen.sv ====
`timescale 1ns/1ps
// Sample tick generator: one pulse every divisor+1 enabled clocks
module uarr_tick_gen #(
  parameter int DIV_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_run,
  input wire logic [DIV_W-1:0] i_divisor,
  output logic o_tick
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } uarr_tick_state_type;

  uarr_tick_state_type st_reg;
  uarr_tick_state_type st_next;

  // ----------------------------------------
  // Down counter
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    if (!i_run) begin
      st_next.cnt = i_divisor;
    end else if (st_reg.cnt == '0) begin
      st_next.cnt = i_divisor;
    end else begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  assign o_tick = i_run && (st_reg.cnt == '0);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

endmodule : uarr_tick_gen

// ==== verilog/uarr_vote3.sv ====
`timescale 1ns/1ps
// Two-of-three majority over the centre samples
module uarr_vote3 (
  input wire logic [2:0] i_samples,
  output logic o_bit
);

  assign o_bit = (i_samples[0] & i_samples[1]) | (i_samples[0] & i_samples[2]) |
                 (i_samples[1] & i_samples[2]);

endmodule : uarr_vote3

// ==== bench/uarr_tx_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Remote serial transmitter
// ----------------------------------------
module uarr_tx_model (
  input wire logic i_clk,
  output logic o_line
);
  // Line idles high
  initial begin
    o_line = 1'b1;
  end
  // exact bit period
  // One frame, start then data LSB first, optional parity, stop
  task automatic send(input logic [7:0] d, input logic par, input logic pbit, input logic stp,
                      input int bclk, input int sclk);
    o_line = 1'b0;
    repeat (bclk) @(negedge i_clk);
    for (int i = 0; i < 8; i++) begin
      o_line = d[i];
      repeat (bclk) @(negedge i_clk);
    end
    if (par) begin
      o_line = pbit;
      repeat (bclk) @(negedge i_clk);
    end
    o_line = stp;
    repeat (sclk) @(negedge i_clk);
    o_line = 1'b1;
  endtask : send
  // Short low spike on an idle line
  task automatic glitch(input int n);
    o_line = 1'b0;
    repeat (n) @(negedge i_clk);
    o_line = 1'b1;
  endtask : glitch
endmodule : uarr_tx_model

// ==== bench/test_uart_async_receiver_recovery.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Receiver testbench
// ----------------------------------------
module test_uart_async_receiver_recovery;
  logic i_clk, i_rst_b, rx_en, dbl, par_en, par_odd, rd, line, rc, fe, pe, ovr, ovrd, ce;
  logic [15:0] div;
  logic [7:0] data;
  int fails, cmp_count, bclk;

  uarr_tx_model uarr_tx_model_inst (.i_clk(i_clk), .o_line(line));
  uarr_receiver uarr_receiver_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce), .i_serial_input_pin(line),
    .i_receive_enable_bit(rx_en), .i_double_speed_select(dbl), .i_parity_enable_bit(par_en),
    .i_parity_odd_select(par_odd), .i_baud_divisor_value(div), .i_serial_data_buffer_read(rd),
    .o_serial_data_buffer(data), .o_receive_complete_flag(rc), .o_frame_error_flag(fe),
    .o_parity_error_flag(pe), .o_overrun_flag(ovr), .o_pin_override(ovrd));

  // Clock, 50 ns period
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Compare helpers
  task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check_data
  task automatic check_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check_flag
  // One-cycle read pulse, flags settle one clock later
  task automatic rd_pulse();
    rd = 1'b1;
    @(negedge i_clk);
    rd = 1'b0;
    @(negedge i_clk);
  endtask : rd_pulse
  // Check head character and its status, then pop it
  task automatic read_check(input logic [7:0] ed, input logic efe, input logic epe, input logic eov);
    check_flag(rc, 1'b1);
    check_data(data, ed);
    check_flag(fe, efe);
    check_flag(pe, epe);
    check_flag(ovr, eov);
    rd_pulse();
  endtask : read_check
  // Send one frame; parity made right unless pbad is set
  task automatic frame(input logic [7:0] d, input logic pbad, input logic stp, input int sclk, input int idle);
    uarr_tx_model_inst.send(d, par_en, (^d) ^ par_odd ^ pbad, stp, bclk, sclk);
    repeat (idle) @(negedge i_clk);
  endtask : frame
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog, well beyond the expected run length
  initial begin
    repeat (60000) @(posedge i_clk);
    fails++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    {rx_en, dbl, par_en, par_odd, rd} = 5'h10;
    ce = 1'b1;
    div = 16'h0000;
    bclk = 16;
    fails = 0;
    cmp_count = 0;
    i_rst_b = 1'b0;
    repeat (12) @(negedge i_clk);
    i_rst_b = 1'b1;
    @(negedge i_clk);
    check_flag(rc, 1'b0);
    check_flag(ovrd, 1'b1);
    frame(8'hA5, 1'b0, 1'b1, 16, 4);
    // Frozen clock enable ignores the read
    ce = 1'b0;
    rd_pulse();
    check_flag(rc, 1'b1);
    check_data(data, 8'hA5);
    ce = 1'b1;
    @(negedge i_clk);
    read_check(8'hA5, 1'b0, 1'b0, 1'b0);
    check_flag(rc, 1'b0);
    par_en = 1'b1;
    for (int m = 0; m < 4; m++) begin
      par_odd = m[1];
      frame(8'h3C + 8'(m), m[0], 1'b1, 16, 4);
      read_check(8'h3C + 8'(m), 1'b0, m[0], 1'b0);
    end
    frame(8'h81, 1'b1, 1'b1, 16, 4);
    par_en = 1'b0;
    read_check(8'h81, 1'b0, 1'b1, 1'b0);
    frame(8'h5A, 1'b0, 1'b0, 16, 20);
    read_check(8'h5A, 1'b1, 1'b0, 1'b0);
    uarr_tx_model_inst.glitch(8);
    repeat (200) @(negedge i_clk);
    check_flag(rc, 1'b0);
    // early starts; held char replaced, newest carries overrun
    frame(8'h11, 1'b0, 1'b1, 10, 0);
    frame(8'h22, 1'b0, 1'b1, 10, 0);
    frame(8'h33, 1'b0, 1'b1, 10, 0);
    frame(8'h44, 1'b0, 1'b1, 16, 4);
    read_check(8'h11, 1'b0, 1'b0, 1'b0);
    read_check(8'h22, 1'b0, 1'b0, 1'b0);
    read_check(8'h44, 1'b0, 1'b0, 1'b1);
    check_flag(rc, 1'b0);
    dbl = 1'b1;
    div = 16'h0002;
    bclk = 24;
    frame(8'hC3, 1'b0, 1'b1, 24, 4);
    read_check(8'hC3, 1'b0, 1'b0, 1'b0);
    fork
      frame(8'h96, 1'b0, 1'b1, 24, 4);
      begin
        repeat (72) @(negedge i_clk);
        rx_en = 1'b0;
        @(negedge i_clk);
        check_flag(ovrd, 1'b0);
      end
    join
    rx_en = 1'b1;
    repeat (4) @(negedge i_clk);
    check_flag(rc, 1'b0);
    frame(8'h01, 1'b0, 1'b1, 24, 0);
    frame(8'h02, 1'b0, 1'b1, 24, 4);
    check_flag(rc, 1'b1);
    rx_en = 1'b0;
    @(negedge i_clk);
    check_flag(rc, 1'b0);
    rx_en = 1'b1;
    @(negedge i_clk);
    check_flag(rc, 1'b0);
    check_data(data, 8'h00);
    frame(8'h0F, 1'b0, 1'b1, 24, 0);
    frame(8'hF0, 1'b0, 1'b1, 24, 4);
    for (int k = 0; k < 4 && rc === 1'b1; k++) begin
      rd_pulse();
    end
    check_flag(rc, 1'b0);
    report_and_stop();
  end
endmodule : test_uart_async_receiver_recovery
